// >>> common/fp_round_cfg.svh
/*
 constants for the rounding and nan control block: register offsets, field
 positions, reset values, rounding encodings, format widths, indefinite values.
 assumes inclusion by bare name from the core and the bench.
*/
`ifndef FP_ROUND_CFG_SVH
`define FP_ROUND_CFG_SVH

`define OFS_STK_CTRL 12'h000
`define OFS_STK_STATUS 12'h004
`define OFS_SIMD_CSR 12'h008
`define OFS_STK_PTR 12'h00c
`define OFS_SIMD_PTR 12'h010

`define STK_RND_LO 10
`define STK_RND_HI 11
`define SIMD_RND_LO 13
`define SIMD_RND_HI 14
`define STK_INV_MASK 0
`define SIMD_INV_MASK 7
`define FLAG_INVALID 0
`define FLAG_PRECISION 5

`define STK_CTRL_RST 32'h0000003f
`define STK_STATUS_RST 32'h00000000
`define SIMD_CSR_RST 32'h00001f80
`define STK_CTRL_MASK 32'h00000f3f
`define STK_STATUS_MASK 32'h0000003f
`define SIMD_CSR_MASK 32'h00007fbf

`define RND_NEAREST 2'b00
`define RND_DOWN 2'b01
`define RND_UP 2'b10
`define RND_ZERO 2'b11

`define SIG_FRAC 7'h42
`define FRAC_HALF 7'h0a
`define FRAC_SINGLE 7'h17
`define FRAC_DOUBLE 7'h34
`define FRAC_EXT 7'h3f

`define INDEF_HALF 16'hfe00
`define INDEF_SINGLE 32'hffc00000
`define INDEF_DOUBLE 64'hfff8000000000000
`define INDEF_EXT 80'hffffc000000000000000
`define EXP_ALL_ONES 16'hffff

`endif

// >>> common/fp_round_pkg.sv
/*
 types for the rounding and nan control block: request and answer carriers,
 format, environment and operation codes.
 assumes nothing beyond the cfg header.
*/
package fp_round_pkg;
	typedef enum logic [1:0] {
		fmt_half = 2'b00,
		fmt_single = 2'b01,
		fmt_double = 2'b10,
		fmt_ext = 2'b11
	} fp_fmt_t;

	typedef enum logic {
		env_stack = 1'b0,
		env_simd = 1'b1
	} fp_env_t;

	typedef enum logic [1:0] {
		op_arith = 2'b00,
		op_compare = 2'b01,
		op_nan = 2'b10,
		op_indef = 2'b11
	} fp_op_t;

	typedef struct packed {
		logic valid;
		fp_op_t op;
		fp_env_t env;
		fp_fmt_t fmt;
		logic sign;
		logic [15:0] exp;
		logic [66:0] sig;
		logic sticky;
		logic [31:0] addr;
	} fp_req_t;

	typedef struct packed {
		logic valid;
		logic [79:0] data;
		logic inexact;
		logic invalid;
	} fp_resp_t;
endpackage

// >>> core/fp_rounding_nan_control.sv
/*
 rounding, nan quieting and indefinite generation for stack and simd fp work,
 with its control and status words on an apb slave.
 assumes the pipeline presents one exact result per request on pclk, already
 aligned to the destination exponent, with the integer bit at sig[66].
*/
// Chosen here: the APB slave port and the address map.
// Notes on behaviour
// RULE_01: inexact results pick one of two bracketing values by the rounding mode.
// RULE_02: rounding error always stays below one unit in the last place.
// RULE_03: mode 00 rounds to nearest, ties go to the even value.
// RULE_04: mode 01 rounds toward minus infinity.
// RULE_05: mode 10 rounds toward plus infinity.
// RULE_06: mode 11 truncates toward zero.
// RULE_07: rounding mode resets to round to nearest even.
// RULE_08: any rounded, changed result sets the sticky precision flag of its environment.
// RULE_09: comparisons, exact results and nan results are not rounded.
// RULE_10: stack rounding field sits at bits 10 and 11 of its control word.
// RULE_11: simd rounding field sits at bits 13 and 14 of simd control status.
// RULE_12: each rounding field governs only its own environment.
// RULE_13: each of single, double, extended has one reserved indefinite qnan.
// RULE_14: nan fraction bits beyond the quiet bit are passed untouched.
// RULE_15: unmasked invalid from snan traps and records the operand address.
// RULE_16: representable results are delivered exactly in half to extended formats.
// RULE_17: half and single conversions both ways are supported.
// RULE_18: single results keep 23 fraction bits; more are rounded away.
// RULE_19: nan is quiet when fraction msb is one, signaling when zero.
// RULE_20: quieting an snan only forces the fraction msb to one.
// RULE_21: guard and sticky of discarded bits feed rounding and the flag.
`timescale 1ns/10ps
`include "fp_round_cfg.svh"

module fp_rounding_nan_control (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire fp_round_pkg::fp_req_t req,
	output fp_round_pkg::fp_resp_t resp,
	output logic trap
);
	logic [31:0] stk_ctrl_reg;
	logic [31:0] stk_status_reg;
	logic [31:0] simd_csr_reg;
	logic [31:0] stk_ptr_reg;
	logic [31:0] simd_ptr_reg;
	fp_round_pkg::fp_resp_t resp_reg;
	logic trap_reg;

	logic wr_en;
	logic [6:0] frac_w;
	logic [6:0] shamt;
	logic [1:0] rnd_mode;
	logic masked;
	logic [66:0] kept;
	logic guard;
	logic sticky;
	logic inc;
	logic [67:0] sum;
	logic carry;
	logic [66:0] mant;
	logic [15:0] exp_r;
	logic is_arith;
	logic is_nan;
	logic is_snan;
	logic inexact_c;
	logic invalid_c;
	logic trap_c;
	logic [79:0] data_c;
	logic stk_prec_set;
	logic stk_inv_set;
	logic simd_prec_set;
	logic simd_inv_set;

	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;

	// each environment reads only its own field, so no cross-influence
	always_comb begin
		if (req.env == fp_round_pkg::env_stack) begin
			rnd_mode = stk_ctrl_reg[`STK_RND_HI:`STK_RND_LO]; // RULE_10 RULE_12
			masked = stk_ctrl_reg[`STK_INV_MASK];
		end else begin
			rnd_mode = simd_csr_reg[`SIMD_RND_HI:`SIMD_RND_LO]; // RULE_11 RULE_12
			masked = simd_csr_reg[`SIMD_INV_MASK];
		end
	end

	always_comb begin
		case (req.fmt)
			fp_round_pkg::fmt_half: frac_w = `FRAC_HALF; // RULE_17
			fp_round_pkg::fmt_single: frac_w = `FRAC_SINGLE; // RULE_18
			fp_round_pkg::fmt_double: frac_w = `FRAC_DOUBLE;
			default: frac_w = `FRAC_EXT;
		endcase
	end

	// shift always at least 3, so guard and sticky positions exist for every format
	assign shamt = `SIG_FRAC - frac_w;
	assign kept = req.sig >> shamt;
	assign guard = req.sig[shamt - 7'h01]; // RULE_21
	assign sticky = (|(req.sig & ((67'h1 << (shamt - 7'h01)) - 67'h1))) | req.sticky; // RULE_21

	// only one of the two neighbours is ever chosen, so error stays under one ulp
	always_comb begin
		case (rnd_mode)
			`RND_NEAREST: inc = guard && (sticky || kept[0]); // RULE_03 RULE_01
			`RND_DOWN: inc = (guard || sticky) && req.sign; // RULE_04
			`RND_UP: inc = (guard || sticky) && !req.sign; // RULE_05
			default: inc = 1'b0; // RULE_06
		endcase
	end

	assign sum = {1'b0, kept} + {67'h0, inc};
	assign carry = sum[frac_w + 7'h01];
	// carry out of the significand renormalises: frac becomes zero, exponent steps
	assign mant = carry ? sum[67:1] : sum[66:0]; // RULE_02
	assign exp_r = carry ? req.exp + 16'h0001 : req.exp;

	assign is_arith = req.op == fp_round_pkg::op_arith;
	assign is_nan = req.op == fp_round_pkg::op_nan;
	assign is_snan = is_nan && !req.sig[`SIG_FRAC - 7'h01]; // RULE_19
	assign inexact_c = req.valid && is_arith && (guard || sticky); // RULE_08 RULE_21
	assign invalid_c = req.valid && (is_snan || req.op == fp_round_pkg::op_indef);
	assign trap_c = req.valid && is_snan && !masked; // RULE_15

	function automatic logic [79:0] pack(input fp_round_pkg::fp_fmt_t f, input logic s,
		input logic [15:0] e, input logic [66:0] m);
		logic [79:0] r;
		r = 80'h0;
		case (f)
			fp_round_pkg::fmt_half: r = {64'h0, s, e[4:0], m[9:0]};
			fp_round_pkg::fmt_single: r = {48'h0, s, e[7:0], m[22:0]};
			fp_round_pkg::fmt_double: r = {16'h0, s, e[10:0], m[51:0]};
			default: r = {s, e[14:0], m[63:0]};
		endcase
		return r;
	endfunction

	function automatic logic [79:0] indef(input fp_round_pkg::fp_fmt_t f);
		logic [79:0] r;
		r = 80'h0;
		case (f)
			fp_round_pkg::fmt_half: r = {64'h0, `INDEF_HALF};
			fp_round_pkg::fmt_single: r = {48'h0, `INDEF_SINGLE};
			fp_round_pkg::fmt_double: r = {16'h0, `INDEF_DOUBLE};
			default: r = `INDEF_EXT;
		endcase
		return r;
	endfunction

	always_comb begin
		case (req.op)
			fp_round_pkg::op_arith: data_c = pack(req.fmt, req.sign, exp_r, mant); // RULE_16
			// compare results bypass rounding altogether
			fp_round_pkg::op_compare: data_c = pack(req.fmt, req.sign, req.exp, kept); // RULE_09
			// payload truncated, never rounded; only the quiet bit is forced
			fp_round_pkg::op_nan: data_c = pack(req.fmt, req.sign, `EXP_ALL_ONES,
				kept | (67'h1 << (frac_w - 7'h01))); // RULE_20 RULE_14 RULE_09
			default: data_c = indef(req.fmt); // RULE_13
		endcase
	end

	// a trapped operation stores no result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_reg <= '0;
		end else begin
			resp_reg.valid <= req.valid && !trap_c;
			resp_reg.data <= data_c;
			resp_reg.inexact <= inexact_c;
			resp_reg.invalid <= invalid_c;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_reg <= 1'b0;
		end else begin
			trap_reg <= trap_c;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stk_ptr_reg <= 32'h0;
			simd_ptr_reg <= 32'h0;
		end else if (trap_c) begin
			if (req.env == fp_round_pkg::env_stack) begin
				stk_ptr_reg <= req.addr; // RULE_15
			end else begin
				simd_ptr_reg <= req.addr; // RULE_15
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stk_ctrl_reg <= `STK_CTRL_RST; // RULE_07
		end else if (wr_en && paddr == `OFS_STK_CTRL) begin
			stk_ctrl_reg <= pwdata & `STK_CTRL_MASK;
		end
	end

	// flag sets win over a software write in the same cycle
	assign stk_prec_set = inexact_c && req.env == fp_round_pkg::env_stack; // RULE_08
	assign stk_inv_set = invalid_c && req.env == fp_round_pkg::env_stack;
	assign simd_prec_set = inexact_c && req.env == fp_round_pkg::env_simd; // RULE_08
	assign simd_inv_set = invalid_c && req.env == fp_round_pkg::env_simd;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stk_status_reg <= `STK_STATUS_RST;
		end else begin
			stk_status_reg <= ((wr_en && paddr == `OFS_STK_STATUS) ?
				(pwdata & `STK_STATUS_MASK) : stk_status_reg)
				| (32'(stk_prec_set) << `FLAG_PRECISION) // RULE_08
				| (32'(stk_inv_set) << `FLAG_INVALID);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			simd_csr_reg <= `SIMD_CSR_RST; // RULE_07
		end else begin
			simd_csr_reg <= ((wr_en && paddr == `OFS_SIMD_CSR) ?
				(pwdata & `SIMD_CSR_MASK) : simd_csr_reg)
				| (32'(simd_prec_set) << `FLAG_PRECISION) // RULE_08
				| (32'(simd_inv_set) << `FLAG_INVALID);
		end
	end

	always_comb begin
		prdata = 32'h0;
		pslverr = 1'b0;
		if (paddr == `OFS_STK_CTRL) begin
			prdata = stk_ctrl_reg;
		end else if (paddr == `OFS_STK_STATUS) begin
			prdata = stk_status_reg;
		end else if (paddr == `OFS_SIMD_CSR) begin
			prdata = simd_csr_reg;
		end else if (paddr == `OFS_STK_PTR) begin
			prdata = stk_ptr_reg;
		end else if (paddr == `OFS_SIMD_PTR) begin
			prdata = simd_ptr_reg;
		end else begin
			pslverr = psel && penable;
		end
	end

	assign resp = resp_reg;
	assign trap = trap_reg;

	AST_RESP_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
		req.valid && is_arith |=> resp.valid)
		else $error("arith answer missing one cycle after request");

	AST_PREC_STACK: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
		inexact_c && req.env == fp_round_pkg::env_stack |=> stk_status_reg[`FLAG_PRECISION])
		else $error("stack precision flag not set");

	AST_PREC_SIMD_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
		inexact_c && req.env == fp_round_pkg::env_simd && !stk_status_reg[`FLAG_PRECISION]
		&& !wr_en |=> !stk_status_reg[`FLAG_PRECISION])
		else $error("simd inexact leaked into stack flag");

	AST_TRUNC: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
		rnd_mode == `RND_ZERO |-> !inc)
		else $error("truncate mode incremented");

	AST_DOWN: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
		rnd_mode == `RND_DOWN && !req.sign |-> !inc)
		else $error("round down grew a positive value");

	AST_UP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
		rnd_mode == `RND_UP && req.sign |-> !inc)
		else $error("round up grew a negative magnitude");

	AST_TIE_EVEN: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
		rnd_mode == `RND_NEAREST && guard && !sticky |-> inc == kept[0])
		else $error("tie not rounded to even");

	AST_INC_NEEDS_LOSS: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
		inc |-> guard || sticky)
		else $error("exact result was changed");

	AST_NO_PREC_COMPARE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
		req.valid && !is_arith |=> !resp.inexact)
		else $error("non-arith result flagged inexact");

	AST_TRAP_PTR: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
		trap_c && req.env == fp_round_pkg::env_stack |=> trap && !resp.valid
		&& stk_ptr_reg == $past(req.addr))
		else $error("trap address not recorded");

	AST_TRAP_PTR_SIMD: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
		trap_c && req.env == fp_round_pkg::env_simd |=> trap && !resp.valid
		&& simd_ptr_reg == $past(req.addr))
		else $error("simd trap address not recorded");

	AST_PTR_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
		!trap_c |=> $stable(stk_ptr_reg) && $stable(simd_ptr_reg))
		else $error("operand pointer moved without a trap");

	AST_MASKED_NO_TRAP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
		masked |-> !trap_c)
		else $error("masked invalid raised a trap");

	AST_STK_FIELD_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
		!(wr_en && paddr == `OFS_STK_CTRL) |=> $stable(stk_ctrl_reg[`STK_RND_HI:`STK_RND_LO]))
		else $error("stack rounding field changed without a write");

	AST_STK_FIELD_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
		wr_en && paddr == `OFS_STK_CTRL
		|=> stk_ctrl_reg[`STK_RND_HI:`STK_RND_LO] == $past(pwdata[`STK_RND_HI:`STK_RND_LO]))
		else $error("stack rounding field write lost");

	AST_SIMD_FIELD_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
		wr_en && paddr == `OFS_SIMD_CSR
		|=> simd_csr_reg[`SIMD_RND_HI:`SIMD_RND_LO] == $past(pwdata[`SIMD_RND_HI:`SIMD_RND_LO]))
		else $error("simd rounding field write lost");

	AST_ENV_STK_FIELD: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
		req.env == fp_round_pkg::env_stack |-> rnd_mode == stk_ctrl_reg[`STK_RND_HI:`STK_RND_LO])
		else $error("stack work used a foreign rounding field");

	AST_ENV_SIMD_FIELD: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
		req.env == fp_round_pkg::env_simd |-> rnd_mode == simd_csr_reg[`SIMD_RND_HI:`SIMD_RND_LO])
		else $error("simd work used a foreign rounding field");

	AST_NEAREST_UP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
		rnd_mode == `RND_NEAREST && guard && sticky |-> inc)
		else $error("nearest mode missed an upper neighbour");

	AST_NEAREST_DOWN: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
		rnd_mode == `RND_NEAREST && !guard |-> !inc)
		else $error("nearest mode rounded up below half");

	AST_DOWN_NEG: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
		rnd_mode == `RND_DOWN && req.sign && (guard || sticky) |-> inc)
		else $error("round down left a negative value too large");

	AST_UP_POS: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
		rnd_mode == `RND_UP && !req.sign && (guard || sticky) |-> inc)
		else $error("round up left a positive value too small");

	AST_EXACT_KEEP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
		is_arith && !guard && !sticky |-> mant == kept && exp_r == req.exp)
		else $error("exact result altered");

	AST_EXACT_NO_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
		req.valid && is_arith && !guard && !sticky |=> !resp.inexact)
		else $error("exact result flagged inexact");

	AST_CARRY_NEEDS_INC: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
		carry |-> inc)
		else $error("renormalised without an increment");

	AST_SNAN_INVALID: assert property (@(posedge pclk) disable iff (!presetn) // RULE_19
		req.valid && is_snan |=> resp.invalid)
		else $error("signaling nan not flagged invalid");

	AST_QNAN_QUIET: assert property (@(posedge pclk) disable iff (!presetn) // RULE_19
		req.valid && is_nan && req.sig[`SIG_FRAC - 7'h01] |=> !resp.invalid)
		else $error("quiet nan flagged invalid");

	AST_INDEF_SINGLE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
		req.valid && req.op == fp_round_pkg::op_indef && req.fmt == fp_round_pkg::fmt_single
		|=> resp.data == {48'h0, `INDEF_SINGLE})
		else $error("single indefinite encoding wrong");

	AST_INDEF_DOUBLE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
		req.valid && req.op == fp_round_pkg::op_indef && req.fmt == fp_round_pkg::fmt_double
		|=> resp.data == {16'h0, `INDEF_DOUBLE})
		else $error("double indefinite encoding wrong");

	AST_PREC_SIMD: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
		inexact_c && req.env == fp_round_pkg::env_simd |=> simd_csr_reg[`FLAG_PRECISION])
		else $error("simd precision flag not set");

	AST_PREC_STICKY: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
		stk_status_reg[`FLAG_PRECISION] && !(wr_en && paddr == `OFS_STK_STATUS)
		|=> stk_status_reg[`FLAG_PRECISION])
		else $error("stack precision flag dropped without a write");
endmodule

// >>> bench/fp_pipe_model.sv
/*
 far side model: the pipeline handing exact results to the rounding block.
 assumes a shared pclk; the bench issues requests through the issue task.
*/
`timescale 1ns/10ps
module fp_pipe_model (
	input wire logic pclk,
	output fp_round_pkg::fp_req_t req
);
	fp_round_pkg::fp_req_t pend;
	logic go;
	initial begin
		req = '0;
		pend = '0;
		go = 1'b0;
	end
	// idle payload flips each cycle so a stale field never passes as live
	always @(posedge pclk) begin
		if (go) begin
			req <= pend;
			go <= 1'b0;
		end else begin
			req <= fp_round_pkg::fp_req_t'({1'b0, ~req[$bits(req)-2:0]});
		end
	end
	// one cycle of valid; returns just after the edge that takes it
	task automatic issue(input fp_round_pkg::fp_req_t r);
		@(posedge pclk);
		pend <= r;
		go <= 1'b1;
		@(posedge pclk);
		@(posedge pclk);
	endtask
endmodule

// >>> bench/fp_rounding_nan_control_tb.sv
/*
 self-checking bench for the rounding and nan control block.
 assumes zero wait apb and a response one cycle after each request.
*/
`timescale 1ns/10ps
`include "fp_round_cfg.svh"
module fp_rounding_nan_control_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trap, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] mode_stk, mode_simd;
	fp_round_pkg::fp_req_t req;
	fp_round_pkg::fp_resp_t resp;
	int num_errors, n_checks, seed;

	fp_rounding_nan_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
		.resp(resp), .trap(trap));
	fp_pipe_model pm (.pclk(pclk), .req(req));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic chk_bit(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_val(input logic [79:0] g, input logic [79:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		// no own limit: a slave that never answers is caught by the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h00000000);
		chk_val(80'(rd), 80'(e));
		chk_bit(err, ee);
	endtask

	function automatic logic [79:0] model(input fp_round_pkg::fp_req_t r,
		input logic [1:0] mode, output logic inx, output logic inv);
		int f;
		logic [66:0] k;
		logic [15:0] e;
		logic g, s, inc;
		case (r.fmt)
			fp_round_pkg::fmt_half: f = 10;
			fp_round_pkg::fmt_single: f = 23;
			fp_round_pkg::fmt_double: f = 52;
			default: f = 63;
		endcase
		k = r.sig >> (66 - f);
		g = r.sig[65 - f];
		s = ((r.sig << (f + 2)) != 67'h0) | r.sticky;
		e = r.exp;
		inv = (r.op == fp_round_pkg::op_nan) & ~r.sig[65];
		inx = (g | s) & (r.op == fp_round_pkg::op_arith);
		case (mode)
			2'b00: inc = g & (s | k[0]);
			2'b01: inc = r.sign & inx;
			2'b10: inc = ~r.sign & inx;
			default: inc = 1'b0;
		endcase
		if (r.op == fp_round_pkg::op_arith) begin
			k = k + 67'(inc);
			e = e + 16'(k[f + 1]);
			// carry out renormalises, which matters for the explicit integer bit
			if (k[f + 1]) begin
				k = k >> 1;
			end
		end
		if (r.op == fp_round_pkg::op_nan) begin
			k[f - 1] = 1'b1;
			e = 16'hffff;
		end
		case (r.fmt)
			fp_round_pkg::fmt_half: model = 80'({r.sign, e[4:0], k[9:0]});
			fp_round_pkg::fmt_single: model = 80'({r.sign, e[7:0], k[22:0]});
			fp_round_pkg::fmt_double: model = 80'({r.sign, e[10:0], k[51:0]});
			default: model = {r.sign, e[14:0], k[63:0]};
		endcase
	endfunction

	task automatic run(input fp_round_pkg::fp_req_t r);
		logic [79:0] ex;
		logic inx, inv;
		ex = model(r, (r.env == fp_round_pkg::env_simd) ? mode_simd : mode_stk, inx, inv);
		pm.issue(r);
		#1;
		chk_bit(resp.valid, 1'b1);
		chk_val(resp.data, ex);
		chk_bit(resp.inexact, inx);
		chk_bit(resp.invalid, inv);
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		finish_test();
	end

	initial begin
		fp_round_pkg::fp_req_t r;
		logic [79:0] ind [4];
		seed = 32'hf749;
		num_errors = 0;
		n_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		ind = '{80'(`INDEF_HALF), 80'(`INDEF_SINGLE), 80'(`INDEF_DOUBLE), `INDEF_EXT};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`OFS_STK_CTRL, `STK_CTRL_RST, 1'b0);
		rd_chk(`OFS_STK_STATUS, `STK_STATUS_RST, 1'b0);
		rd_chk(`OFS_SIMD_CSR, `SIMD_CSR_RST, 1'b0);
		rd_chk(`OFS_STK_PTR, 32'h00000000, 1'b0);
		rd_chk(12'h014, 32'h00000000, 1'b1);
		// stack and simd always run different modes, so a crossed field shows
		for (int m = 0; m < 4; m++) begin
			mode_stk = 2'(m);
			mode_simd = 2'(3 - m);
			apb(1'b1, `OFS_STK_CTRL, `STK_CTRL_RST | (32'(mode_stk) << 10));
			apb(1'b1, `OFS_SIMD_CSR, `SIMD_CSR_RST | (32'(mode_simd) << 13));
			rd_chk(`OFS_STK_CTRL, `STK_CTRL_RST | (32'(mode_stk) << 10), 1'b0);
			rd_chk(`OFS_SIMD_CSR, `SIMD_CSR_RST | (32'(mode_simd) << 13), 1'b0);
			for (int i = 0; i < 16; i++) begin
				r = '0;
				r.valid = 1'b1;
				r.op = (i % 5 == 4) ? fp_round_pkg::op_compare : fp_round_pkg::op_arith;
				r.env = fp_round_pkg::fp_env_t'(1'($random(seed)));
				r.fmt = fp_round_pkg::fp_fmt_t'(2'($random(seed)));
				r.sign = 1'($random(seed));
				r.exp = 16'h0008 + 16'(3'($random(seed)));
				r.sig = {1'b1, 2'($random(seed)), 32'($random(seed)), 32'($random(seed))};
				r.sticky = 1'($random(seed));
				if (i < 3) begin
					r.fmt = fp_round_pkg::fmt_single;
					r.sticky = 1'b0;
					r.sig[43:0] = {i[0], i < 2, 42'h0};
				end
				run(r);
			end
		end
		apb(1'b1, `OFS_STK_STATUS, 32'h00000000);
		apb(1'b1, `OFS_SIMD_CSR, `SIMD_CSR_RST);
		r.op = fp_round_pkg::op_arith;
		r.env = fp_round_pkg::env_stack;
		r.sig[0] = 1'b1;
		run(r);
		rd_chk(`OFS_STK_STATUS, 32'h00000020, 1'b0);
		rd_chk(`OFS_SIMD_CSR, `SIMD_CSR_RST, 1'b0);
		for (int f = 0; f < 4; f++) begin
			r.fmt = fp_round_pkg::fp_fmt_t'(2'(f));
			r.op = fp_round_pkg::op_nan;
			r.sig = {1'b1, 2'($random(seed)), 32'($random(seed)), 32'($random(seed))};
			run(r);
			r.op = fp_round_pkg::op_indef;
			pm.issue(r);
			#1;
			chk_val(resp.data, ind[f]);
			chk_bit(resp.invalid, 1'b1);
		end
		apb(1'b1, `OFS_STK_CTRL, (`STK_CTRL_RST & 32'hfffffffe) | (32'(mode_stk) << 10));
		r.op = fp_round_pkg::op_nan;
		r.sig[65:64] = 2'b01;
		r.addr = $random(seed);
		pm.issue(r);
		#1;
		chk_bit(trap, 1'b1);
		chk_bit(resp.valid, 1'b0);
		apb(1'b1, `OFS_STK_PTR, ~r.addr);
		rd_chk(`OFS_STK_PTR, r.addr, 1'b0);
		rd_chk(`OFS_STK_STATUS, 32'h00000021, 1'b0);
		finish_test();
	end
endmodule
